// File: common/cip_pkg.sv
/*
 shared constants for the card command engine: register map, command
 and parameter codes, status words, retry figures and engine states.
 assumes: referenced as cip_pkg:: by the engine, the code keeper and the bench, never imported.
*/
`default_nettype none
package cip_pkg;
	// register byte offsets on the apb window
	localparam logic [7:0] A_CMD = 8'h00;
	localparam logic [7:0] A_CTRL = 8'h04;
	localparam logic [7:0] A_STAT = 8'h08;
	localparam logic [7:0] A_ACC = 8'h0c;
	localparam logic [7:0] A_DATA0 = 8'h10;
	localparam logic [7:0] A_DATA1 = 8'h14;
	localparam logic [7:0] A_DATA2 = 8'h18;
	localparam logic [7:0] A_DATA3 = 8'h1c;
	localparam logic [7:0] A_RESP0 = 8'h20;
	localparam logic [7:0] A_RESP1 = 8'h24;
	localparam logic [7:0] A_REC0 = 8'h30;
	localparam logic [7:0] A_REC1 = 8'h34;
	localparam logic [7:0] A_REC2 = 8'h38;
	localparam logic [7:0] A_REC3 = 8'h3c;
	localparam int ADDR_SHIFT = 2; // byte address to word index
	localparam logic [3:0] STRB_ALL = 4'hf; // only whole-word writes
	// control register bit positions
	localparam int CTRL_GO = 0;
	localparam int CTRL_DIS = 1;
	// storage sizes
	localparam int N_DATA = 4; // command data words, 16 bytes
	localparam int N_RESP = 2; // response words
	localparam int N_REC = 4; // records of the cyclic file
	localparam logic [7:0] REC_LEN = 8'h04; // bytes per record
	// instruction and parameter codes
	localparam logic [7:0] INS_INC = 8'h32;
	localparam logic [7:0] INS_VERIFY = 8'h20;
	localparam logic [7:0] INS_CHANGE = 8'h24;
	localparam logic [7:0] TAG_INC = 8'h84;
	localparam logic [7:0] P2_INC = 8'h00;
	localparam logic [7:0] P1_CUR_FILE = 8'h00;
	localparam logic [7:0] P1_SHORT_ID_HDR = 8'h80;
	localparam logic [7:0] P1_CODE = 8'h00;
	localparam logic [7:0] QUAL_RFU = 8'h60; // must read zero
	localparam logic [7:0] QUAL_REF = 8'h1f; // key reference number
	localparam logic [7:0] LC_EMPTY = 8'h00;
	localparam logic [7:0] LC_VERIFY = 8'h08;
	localparam logic [7:0] LC_CHANGE = 8'h10;
	localparam logic [7:0] LC_INC_LIM = 8'h80;
	// secret code store
	localparam logic [1:0] RETRY_INIT = 2'h3;
	localparam logic [63:0] CODE_RESET = 64'h3132333435363738; // arbitrary
	// status words
	localparam logic [15:0] SW_OK = 16'h9000;
	localparam logic [15:0] SW_LEFT = 16'h63c0;
	localparam logic [15:0] SW_BLOCKED = 16'h6983;
	localparam logic [15:0] SW_SEC = 16'h6982;
	localparam logic [15:0] SW_DISABLED = 16'h6984;
	localparam logic [15:0] SW_NO_INC = 16'h6581;
	localparam logic [15:0] SW_WRONG_LEN = 16'h6700;
	localparam logic [15:0] SW_BAD_P = 16'h6b00;
	localparam logic [15:0] SW_REF_NF = 16'h6a88;
	localparam logic [15:0] SW_FILE_NF = 16'h6a82;
	localparam logic [15:0] SW_INS_BAD = 16'h6d00;
	// engine states
	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_CODE} cip_state_t;
endpackage
`default_nettype wire

// File: test/cip_apb_host.sv
/*
 apb master standing in for the terminal side of the command engine.
 assumes: the caller enters xfer right after a rising edge of pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module cip_apb_host (
	input wire logic pclk,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
		pstrb = 4'hf;
	end

	// one whole transfer; waits for the answer however long it takes
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// request held until pready seen at a rising edge
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle cycle so no signal is driven twice in a step
		@(posedge pclk);
	endtask
endmodule // cip_apb_host
`default_nettype wire

// File: test/testbench.sv
/*
 self-checking bench for the command engine: code test, code change,
 retry and blocking, increase on the cyclic file, bus refusals.
 assumes: cip_core and cip_apb_host compiled before, ce held high.
*/
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	int error_cnt = 0;
	int num_checks = 0;
	logic dis = 1'b0; // code disabled bit kept with every go
	logic [31:0] st, rv;
	logic er;
	localparam logic [63:0] BAD = 64'h0102030405060708;
	localparam logic [63:0] NEWC = 64'h3837363534333231;

	// 250 mhz clock
	always #2 pclk = ~pclk;

	cip_apb_host host (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
		.pready(pready), .pslverr(pslverr), .prdata(prdata));
	cip_core dut (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.pslverr(pslverr), .prdata(prdata));

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		host.xfer(1'b1, a, d, rv, er);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		host.xfer(1'b0, a, 32'h00000000, r, er);
	endtask

	// issue a command, poll until not busy, compare status word
	task automatic sw(input logic [31:0] c, input logic [15:0] e);
		int n;
		n = 0;
		wr(cip_pkg::A_CMD, c);
		wr(cip_pkg::A_CTRL, {30'h0, dis, 1'b1});
		st = 32'h00010000;
		while (st[16] !== 1'b0 && n < 20) begin
			rd(cip_pkg::A_STAT, st);
			n++;
		end
		check({31'h0, st[16]}, 32'h0);
		check({16'h0, st[15:0]}, {16'h0, e});
	endtask

	// code test with key reference 01
	task automatic vfy(input logic [63:0] k, input logic [15:0] e);
		wr(cip_pkg::A_DATA0, k[63:32]);
		wr(cip_pkg::A_DATA1, k[31:0]);
		sw(32'h08010020, e);
	endtask

	// change: old code in bytes 1-8, new code in bytes 9-16
	task automatic chg(input logic [63:0] o, input logic [63:0] n,
		input logic [15:0] e);
		wr(cip_pkg::A_DATA2, n[63:32]);
		wr(cip_pkg::A_DATA3, n[31:0]);
		wr(cip_pkg::A_DATA0, o[63:32]);
		wr(cip_pkg::A_DATA1, o[31:0]);
		sw(32'h10010024, e);
	endtask

	// single exit point
	task automatic give_verdict();
		if (error_cnt == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// hang guard
	initial begin
		#200000;
		error_cnt++;
		give_verdict();
	end

	// main sequence
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(cip_pkg::A_STAT, st);
		check(st, 32'h00060000);
		rd(8'h28, st);
		check({31'h0, er}, 32'h1);
		wr(cip_pkg::A_STAT, 32'h1);
		check({31'h0, er}, 32'h1);
		wr(cip_pkg::A_ACC, 32'h01003284);
		rd(cip_pkg::A_ACC, st);
		check(st, 32'h01003284);
		// retry counter and code test
		sw(32'h00010020, 16'h63c3);
		vfy(BAD, 16'h63c2);
		vfy(BAD, 16'h63c1);
		vfy(cip_pkg::CODE_RESET, cip_pkg::SW_OK);
		rd(cip_pkg::A_STAT, st);
		check({28'h0, st[20:17]}, 32'hb);
		sw(32'h00010020, 16'h63c3);
		sw(32'h08000020, cip_pkg::SW_BAD_P);
		sw(32'h08610020, cip_pkg::SW_BAD_P);
		dis = 1'b1;
		vfy(cip_pkg::CODE_RESET, cip_pkg::SW_DISABLED);
		dis = 1'b0;
		// code change
		chg(BAD, NEWC, 16'h63c2);
		vfy(cip_pkg::CODE_RESET, cip_pkg::SW_OK);
		chg(cip_pkg::CODE_RESET, NEWC, cip_pkg::SW_OK);
		vfy(cip_pkg::CODE_RESET, 16'h63c2);
		vfy(NEWC, cip_pkg::SW_OK);
		sw(32'h08010024, cip_pkg::SW_WRONG_LEN);
		// increase: value 0102, then 05 on top of it
		wr(cip_pkg::A_DATA0, 32'h01020000);
		sw(32'h02000032, cip_pkg::SW_OK);
		rd(cip_pkg::A_RESP0, st);
		check(st, 32'h00000102);
		rd(cip_pkg::A_RESP1, st);
		check(st, 32'h00000102);
		rd(cip_pkg::A_STAT, st);
		check({24'h0, st[31:24]}, 32'h6);
		wr(cip_pkg::A_DATA0, 32'h05000000);
		sw(32'h01000032, cip_pkg::SW_OK);
		rd(cip_pkg::A_REC0, st);
		check(st, 32'h00000107);
		rd(cip_pkg::A_REC1, st);
		check(st, 32'h00000102);
		wr(cip_pkg::A_DATA0, 32'hfffffffe);
		sw(32'h04000032, cip_pkg::SW_NO_INC);
		rd(cip_pkg::A_REC0, st);
		check(st, 32'h00000107);
		sw(32'h02010032, cip_pkg::SW_BAD_P);
		// short id select: wrong id refused, matching id accepted
		sw(32'h01008132, cip_pkg::SW_FILE_NF);
		sw(32'h04008032, cip_pkg::SW_NO_INC);
		sw(32'h80000032, cip_pkg::SW_WRONG_LEN);
		sw(32'h00000032, cip_pkg::SW_WRONG_LEN);
		wr(cip_pkg::A_ACC, 32'h01003285);
		sw(32'h02000032, cip_pkg::SW_SEC);
		// three misses block the code
		wr(cip_pkg::A_ACC, 32'h01013284);
		vfy(BAD, 16'h63c2);
		vfy(BAD, 16'h63c1);
		vfy(BAD, 16'h63c0);
		vfy(NEWC, cip_pkg::SW_BLOCKED);
		sw(32'h00010020, cip_pkg::SW_BLOCKED);
		rd(cip_pkg::A_STAT, st);
		check({31'h0, st[19]}, 32'h1);
		wr(cip_pkg::A_DATA0, 32'h01000000);
		sw(32'h01000032, cip_pkg::SW_SEC);
		give_verdict();
	end
endmodule // testbench
`default_nettype wire

// File: verilog/cip_code_keeper.sv
/*
 secret code store with its retry counter and blocked flag.
 assumes: chk is a one-cycle pulse with given and fresh held stable;
 its state stands for the card's persistent store.
*/
`timescale 1ns/1ns
`default_nettype none
module cip_code_keeper (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic chk,
	input wire logic chg,
	input wire logic [63:0] given,
	input wire logic [63:0] fresh,
	output logic done,
	output logic match,
	output logic blocked,
	output logic [1:0] retries
);
	// all keeper state
	typedef struct packed {
		logic [63:0] ref_code; // stored reference
		logic [1:0] retries; // attempts left
		logic blocked; // code locked out
		logic done; // check finished pulse
		logic match; // last check result
	} cip_keep_t;

	localparam cip_keep_t KEEP_RST = '{
		ref_code: cip_pkg::CODE_RESET,
		retries: cip_pkg::RETRY_INIT,
		default: '0
	};

	cip_keep_t q;
	cip_keep_t d;

	// compare, count and store
	always_comb begin
		d = q;
		d.done = 1'b0;
		if (chk && !q.blocked) begin
			d.done = 1'b1;
			d.match = given == q.ref_code;
			if (d.match) begin
				d.retries = cip_pkg::RETRY_INIT;
				if (chg) begin
					d.ref_code = fresh;
				end
			end else begin
				// count down, the value is left unchanged
				d.retries = q.retries - 2'h1;
				d.blocked = q.retries == 2'h1;
			end
		end
	end

	// state register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= KEEP_RST;
		end else if (ce) begin
			q <= d;
		end
	end

	assign done = q.done;
	assign match = q.match;
	assign blocked = q.blocked;
	assign retries = q.retries;
endmodule // cip_code_keeper
`default_nettype wire

// File: verilog/cip_core.sv
/*
 cip_core: card command engine for increase on a cyclic file, code
 verification and code change, reached over an apb register window.
 assumes: one clock pclk, async active-low presetn, ce freezes all
 state; software loads command and data words, then sets go.
*/
// Implementation choices: the APB interface to the registers and the placing of the registers.
// Operation
// - increase adds value to newest record, stores oldest
// - written record becomes record 1
// - increase needs tag 84 with ins 32, condition met
// - no increase when sum exceeds all-ff record
// - p2 zero, p1 current file or short id
// - length 1 to 127, records up to 127; code takes length 1 to 4, records of 4 bytes
// - response is new record then added value
// - verified status holds on every channel
// - verify only when code enabled and unblocked
// - match reloads attempts counter to 3
// - mismatch decrements counter on any channel
// - third mismatch blocks code, status 63c0
// - verify on blocked code answers 6983
// - blocked code keeps dependent conditions unmet
// - empty verify reports attempts left as 63cx
// - failed verify reports attempts left as 63cx
// - qualifier b8 picks global or specific; zero refused
// - qualifier b7 b6 zero, reference 01 to 1f
// - changed code takes effect on all channels
// - change only when enabled, unblocked; old and new
// - old matches: reload counter, store new code
// - old mismatches: decrement, keep, block after three
// - change carries sixteen bytes, old then new
`timescale 1ns/1ns
`default_nettype none
module cip_core (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic pready,
	output logic pslverr,
	output logic [31:0] prdata
);
	// all engine state
	typedef struct packed {
		logic pready; // apb answer
		logic pslverr; // apb error
		logic [31:0] prdata; // apb read data
		logic [7:0] ins; // command instruction
		logic [7:0] p1; // first parameter
		logic [7:0] p2; // second parameter
		logic [7:0] lc; // data length
		logic dis; // code disabled
		logic [7:0] tag; // access rule mode tag
		logic [7:0] rins; // access rule instruction
		logic need; // rule asks for verified code
		logic [4:0] short_file_id; // file's own short id
		logic [7:0] keyref; // qualifier of the code
		logic [cip_pkg::N_DATA-1:0][31:0] data; // command data
		logic [cip_pkg::N_RESP-1:0][31:0] resp; // response data
		logic [cip_pkg::N_REC-1:0][31:0] rec; // cyclic records
		logic [1:0] cur; // index of record 1
		logic [15:0] sw; // last status word
		logic [7:0] rlen; // response length in bytes
		logic busy; // command running
		logic verified; // shared security status
		logic chk; // keeper check pulse
		cip_pkg::cip_state_t st; // engine state
	} cip_core_t;

	cip_core_t q;
	cip_core_t d;
	logic kp_done; // keeper finished
	logic kp_match; // keeper result
	logic kp_blocked; // code locked out
	logic [1:0] kp_retries; // attempts left
	logic [1:0] didx; // data word index
	logic [1:0] ridx; // record number minus one
	logic sidx; // response word index
	logic [1:0] oldest; // index of oldest record
	logic [31:0] addv; // value to add, right aligned
	logic [32:0] sum; // sum with carry
	logic acc_ok; // increase rule fulfilled
	logic p1_ok; // file selection valid
	logic lc_ok; // increase length valid
	logic qual_ok; // code qualifier valid
	logic inc_go; // increase commits this cycle

	// code store with its retry counter
	cip_code_keeper u_keep (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.chk(q.chk),
		.chg(q.ins == cip_pkg::INS_CHANGE),
		.given({q.data[0], q.data[1]}),
		.fresh({q.data[2], q.data[3]}),
		.done(kp_done),
		.match(kp_match),
		.blocked(kp_blocked),
		.retries(kp_retries)
	);

	// address to word index
	assign didx = 2'((paddr - cip_pkg::A_DATA0) >> cip_pkg::ADDR_SHIFT);
	assign ridx = 2'((paddr - cip_pkg::A_REC0) >> cip_pkg::ADDR_SHIFT);
	assign sidx = 1'((paddr - cip_pkg::A_RESP0) >> cip_pkg::ADDR_SHIFT);

	// cyclic file: oldest sits just before record 1
	assign oldest = q.cur - 2'h1;
	assign addv = q.data[0] >> {3'(cip_pkg::REC_LEN) - q.lc[2:0], 3'h0};
	assign sum = {1'b0, q.rec[q.cur]} + {1'b0, addv};

	// increase checks
	assign p1_ok = q.p1 == cip_pkg::P1_CUR_FILE
		|| q.p1 == (cip_pkg::P1_SHORT_ID_HDR
		| {3'h0, q.short_file_id});
	assign lc_ok = q.lc != cip_pkg::LC_EMPTY
		&& q.lc < cip_pkg::LC_INC_LIM
		&& q.lc <= cip_pkg::REC_LEN;
	assign acc_ok = q.tag == cip_pkg::TAG_INC
		&& q.rins == cip_pkg::INS_INC
		&& (!q.need || (q.verified && !kp_blocked));
	assign inc_go = q.st == cip_pkg::ST_EXEC
		&& q.ins == cip_pkg::INS_INC && q.p2 == cip_pkg::P2_INC
		&& p1_ok && lc_ok && acc_ok && !sum[32];

	// qualifier: rfu bits clear, reference nonzero
	assign qual_ok = (q.p2 & cip_pkg::QUAL_RFU) == 8'h00
		&& (q.p2 & cip_pkg::QUAL_REF) != 8'h00;

	// next state: bus slave and command engine
	always_comb begin
		logic [1:0] pad;
		pad = 2'h0;
		d = q;
		d.chk = 1'b0;
		// access phase answered one cycle after it opens
		d.pready = psel && penable && !q.pready;
		if (psel && penable && !q.pready) begin
			d.pslverr = 1'b0;
			d.prdata = 32'h0;
			case (paddr)
				cip_pkg::A_CMD: begin
					d.prdata = {q.lc, q.p2, q.p1, q.ins};
				end
				cip_pkg::A_CTRL: begin
					d.prdata = {30'h0, q.dis, 1'b0};
				end
				cip_pkg::A_ACC: begin
					d.prdata = {q.keyref, 2'h0, q.short_file_id,
						q.need, q.rins, q.tag};
				end
				cip_pkg::A_DATA0, cip_pkg::A_DATA1,
				cip_pkg::A_DATA2, cip_pkg::A_DATA3: begin
					d.prdata = q.data[didx];
				end
				cip_pkg::A_STAT: begin
					d.prdata = {q.rlen, 3'h0, q.verified, kp_blocked,
						kp_retries, q.busy, q.sw};
					d.pslverr = pwrite; // read only
				end
				cip_pkg::A_RESP0, cip_pkg::A_RESP1: begin
					d.prdata = q.resp[sidx];
					d.pslverr = pwrite;
				end
				cip_pkg::A_REC0, cip_pkg::A_REC1,
				cip_pkg::A_REC2, cip_pkg::A_REC3: begin
					// read by record number, renumbered view
					d.prdata = q.rec[q.cur + ridx];
					d.pslverr = pwrite;
				end
				default: begin
					d.pslverr = 1'b1; // unmapped
				end
			endcase
			// partial writes and writes while busy refused
			if (pwrite && (pstrb != cip_pkg::STRB_ALL || q.busy)) begin
				d.pslverr = 1'b1;
			end
		end
		// a write lands on the edge that completes the transfer
		if (psel && penable && q.pready && pwrite && !q.pslverr) begin
			case (paddr)
				cip_pkg::A_CMD: begin
					{d.lc, d.p2, d.p1, d.ins} = pwdata;
				end
				cip_pkg::A_CTRL: begin
					d.dis = pwdata[cip_pkg::CTRL_DIS];
					if (pwdata[cip_pkg::CTRL_GO]) begin
						d.busy = 1'b1;
						d.st = cip_pkg::ST_EXEC;
					end
				end
				cip_pkg::A_ACC: begin
					{d.keyref, pad, d.short_file_id,
						d.need, d.rins, d.tag} = pwdata;
				end
				cip_pkg::A_DATA0, cip_pkg::A_DATA1,
				cip_pkg::A_DATA2, cip_pkg::A_DATA3: begin
					d.data[didx] = pwdata;
				end
				default: begin
				end
			endcase
		end
		// command engine
		case (q.st)
			cip_pkg::ST_EXEC: begin
				d.st = cip_pkg::ST_IDLE;
				d.busy = 1'b0;
				d.rlen = 8'h00;
				if (q.ins == cip_pkg::INS_INC) begin
					// increase, checks in priority order
					if (q.p2 != cip_pkg::P2_INC) begin
						d.sw = cip_pkg::SW_BAD_P;
					end else if (!p1_ok) begin
						d.sw = cip_pkg::SW_FILE_NF;
					end else if (!lc_ok) begin
						d.sw = cip_pkg::SW_WRONG_LEN;
					end else if (!acc_ok) begin
						d.sw = cip_pkg::SW_SEC;
					end else if (sum[32]) begin
						d.sw = cip_pkg::SW_NO_INC;
					end else begin
						d.rec[oldest] = sum[31:0];
						d.cur = oldest;
						d.resp[0] = sum[31:0];
						d.resp[1] = addv;
						d.rlen = cip_pkg::REC_LEN + q.lc;
						d.sw = cip_pkg::SW_OK;
					end
				end else if (q.ins == cip_pkg::INS_VERIFY
					|| q.ins == cip_pkg::INS_CHANGE) begin
					// code commands share the qualifier checks
					if (q.p1 != cip_pkg::P1_CODE || !qual_ok) begin
						d.sw = cip_pkg::SW_BAD_P;
					end else if (q.p2 != q.keyref) begin
						d.sw = cip_pkg::SW_REF_NF;
					end else if (kp_blocked) begin
						d.sw = cip_pkg::SW_BLOCKED;
					end else if (q.dis) begin
						d.sw = cip_pkg::SW_DISABLED;
					end else if (q.ins == cip_pkg::INS_VERIFY
						&& q.lc == cip_pkg::LC_EMPTY) begin
						// query only, nothing tested
						d.sw = cip_pkg::SW_LEFT | 16'(kp_retries);
					end else if (q.lc != (q.ins == cip_pkg::INS_VERIFY ?
						cip_pkg::LC_VERIFY : cip_pkg::LC_CHANGE)) begin
						d.sw = cip_pkg::SW_WRONG_LEN;
					end else begin
						d.chk = 1'b1;
						d.busy = 1'b1;
						d.st = cip_pkg::ST_CODE;
					end
				end else begin
					d.sw = cip_pkg::SW_INS_BAD;
				end
			end
			cip_pkg::ST_CODE: begin
				// status only after the counter is stored
				if (kp_done) begin
					d.st = cip_pkg::ST_IDLE;
					d.busy = 1'b0;
					// one flag for all channels
					d.verified = kp_match;
					d.sw = kp_match ? cip_pkg::SW_OK
						: cip_pkg::SW_LEFT | 16'(kp_retries);
				end
			end
			default: begin
			end
		endcase
	end

	// state register, frozen while ce is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else if (ce) begin
			q <= d;
		end
	end

	assign pready = q.pready;
	assign pslverr = q.pslverr;
	assign prdata = q.prdata;

	// checks on enabled edges only
	default clocking cb @(posedge pclk iff ce);
	endclocking
	default disable iff (!presetn);

	chk_inc_sum_store: assert property (
		inc_go |=> q.rec[$past(oldest)] == $past(sum[31:0]))
		else $error("increase sum not in oldest record");

	chk_inc_renumber: assert property (
		inc_go |=> q.cur == $past(oldest) && q.rec[q.cur] == q.resp[0])
		else $error("written record is not record one");

	chk_inc_rule: assert property (
		inc_go |-> q.tag == cip_pkg::TAG_INC && q.rins == cip_pkg::INS_INC
			&& (!q.need || q.verified))
		else $error("increase without fulfilled rule");

	chk_inc_overflow: assert property (
		q.st == cip_pkg::ST_EXEC && q.ins == cip_pkg::INS_INC && sum[32]
		|=> q.rec == $past(q.rec) && q.sw != cip_pkg::SW_OK)
		else $error("overflowing increase was applied");

	chk_inc_response: assert property (
		inc_go |=> q.rlen == $past(q.lc) + cip_pkg::REC_LEN
			&& q.resp[1] == $past(addv))
		else $error("increase response malformed");

	chk_check_gate: assert property (
		q.chk |-> !kp_blocked && !q.dis ##1 kp_done)
		else $error("code checked while blocked or disabled");

	chk_retry_reload: assert property (
		kp_done && kp_match |-> kp_retries == cip_pkg::RETRY_INIT)
		else $error("match did not reload attempts");

	chk_block_status: assert property (
		kp_done && !kp_match && kp_retries == 2'h0
		|-> kp_blocked ##1 q.sw == cip_pkg::SW_LEFT && !q.busy)
		else $error("third mismatch not blocked with 63c0");

	chk_fail_count: assert property (
		q.st == cip_pkg::ST_CODE && kp_done && !kp_match
		|=> q.sw == (cip_pkg::SW_LEFT | 16'($past(kp_retries))))
		else $error("failed check gave wrong count");

	chk_blocked_answer: assert property (
		q.st == cip_pkg::ST_EXEC && q.ins == cip_pkg::INS_VERIFY
		&& q.p1 == cip_pkg::P1_CODE && qual_ok && q.p2 == q.keyref
		&& kp_blocked |=> q.sw == cip_pkg::SW_BLOCKED && !q.busy)
		else $error("blocked code not answered 6983");

	chk_blocked_rule: assert property (
		kp_blocked && q.need |-> !acc_ok)
		else $error("blocked code fulfils a condition");

	cov_increase: cover property (inc_go);
	cov_code_match: cover property (kp_done && kp_match);
	cov_code_block: cover property (kp_done && kp_blocked);
	cov_blocked_cmd: cover property (q.sw == cip_pkg::SW_BLOCKED);
endmodule // cip_core
`default_nettype wire
